// File: src/lvds_rx_pkg.sv
// Purpose: Shared constants, types and decoders of the receive lane.
// Assumes: One system clock; both lane clocks arrive as plain inputs.
// Notes:   Register offsets are byte addresses on a 32-bit word port.

`default_nettype none

package lvds_rx_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W          = 4;
	localparam int unsigned DATA_W          = 32;
	localparam logic [3:0]  OFF_CTRL        = 4'h0;
	localparam logic [3:0]  OFF_STATUS      = 4'h4;
	localparam logic [3:0]  OFF_WORD        = 4'h8;
	localparam logic [3:0]  OFF_COUNT       = 4'hC;

	localparam int unsigned CTRL_DESER_BIT  = 0;
	localparam int unsigned CTRL_WIDTH_LSB  = 4;
	localparam int unsigned CTRL_CONN_LSB   = 8;
	localparam int unsigned CTRL_ODT_BIT    = 12;
	localparam int unsigned STAT_SLIP_BIT   = 0;
	localparam int unsigned STAT_PAD_BIT    = 1;

	localparam logic        RST_DESER       = 1'b1;
	localparam logic [3:0]  RST_WIDTH       = 4'h8;
	localparam logic        RST_ODT         = 1'b0;

	// ----------------------------------------------------------------
	// Lane geometry and timing
	// ----------------------------------------------------------------
	localparam int unsigned WORD_W          = 8;
	localparam logic [3:0]  MIN_WIDTH       = 4'h2;
	localparam logic [3:0]  MAX_WIDTH       = 4'h8;
	localparam logic [3:0]  COUNT_TOP       = 4'hF;
	localparam int unsigned ODT_OHMS        = 100;
	localparam int unsigned CLK_PERIOD_NS   = 40;

	typedef enum logic [1:0] {
		CONN_NORMAL,
		CONN_PLL_CLKIN,
		CONN_PLL_EXTFB
	} conn_e;

	// Out-of-range factors are pulled to the nearest legal one.
	function automatic logic [3:0] clamp_width(input logic [3:0] w);
		if (w < MIN_WIDTH)
			return MIN_WIDTH;
		if (w > MAX_WIDTH)
			return MAX_WIDTH;
		return w;
	endfunction

	function automatic logic [WORD_W-1:0] width_mask(input logic [3:0] w);
		logic [WORD_W-1:0] m;
		m = '0;
		for (int i = 0; i < WORD_W; i++)
			m[i] = (i < int'(w));
		return m;
	endfunction

endpackage

`default_nettype wire

// File: src/lane_if.sv
// Purpose: Carries sampled lane events between control and shifter.
// Assumes: Both ends run on the same system clock.
// Notes:   Strobes are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none

interface lane_if;
	logic                          enable;
	logic [3:0]                    width;
	logic                          bit_rise;
	logic                          bit_value;
	logic                          word_rise;
	logic [lvds_rx_pkg::WORD_W-1:0] word;
	logic                          word_valid;
	logic                          slip;

	modport core (
		output enable, width, bit_rise, bit_value, word_rise,
		input  word, word_valid, slip
	);
	modport shifter (
		input  enable, width, bit_rise, bit_value, word_rise,
		output word, word_valid, slip
	);
endinterface

`default_nettype wire

// File: src/lane_shifter.sv
// Purpose: Shifts serial bits and cuts them into aligned words.
// Assumes: Edge strobes come already synchronised and filtered.
// Notes:   The first word after enabling is flagged as slipped only if it carries other than width bits.
`timescale 1ns/1ns
`default_nettype none

module lane_shifter (
	input  wire logic clk,
	input  wire logic rst_n,
	lane_if.shifter   lane
);
	import lvds_rx_pkg::*;

	logic [WORD_W-1:0] shreg;
	logic [3:0]        bits_seen;

	// ----------------------------------------------------------------
	// Serial shift, newest bit in the low position
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n)
			shreg <= '0;
		else if (lane.enable && lane.bit_rise)
			shreg <= {shreg[WORD_W-2:0], lane.bit_value};
	end

	// A bit arriving with the word edge belongs to the next word.
	always_ff @(posedge clk) begin
		if (!rst_n || !lane.enable)
			bits_seen <= 4'h0;
		else if (lane.word_rise)
			bits_seen <= lane.bit_rise ? 4'h1 : 4'h0;
		else if (lane.bit_rise && bits_seen != COUNT_TOP)
			bits_seen <= 4'(bits_seen + 4'h1);
	end

	// ----------------------------------------------------------------
	// Word capture on the word clock edge
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lane.word       <= '0;
			lane.word_valid <= 1'b0;
			lane.slip       <= 1'b0;
		end else begin
			lane.word_valid <= lane.enable && lane.word_rise;
			// A bit count other than the factor means the word clock
			// is not the bit clock divided down as it should be.
			lane.slip <= lane.enable && lane.word_rise
				&& bits_seen != lane.width;
			if (lane.enable && lane.word_rise)
				lane.word <= shreg & width_mask(lane.width);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_shift_in;
		lane.enable && lane.bit_rise |=>
			shreg[0] == $past(lane.bit_value)
			&& shreg[WORD_W-1:1] == $past(shreg[WORD_W-2:0]);
	endproperty
	a_shift_in: assert property (p_shift_in)
		else $error("serial bit not shifted in");

	property p_word_latch;
		lane.enable && lane.word_rise |=> lane.word_valid
			&& lane.word == ($past(shreg) & width_mask($past(lane.width)));
	endproperty
	a_word_latch: assert property (p_word_latch)
		else $error("word not latched on word edge");

	property p_slip_flag;
		lane.enable && lane.word_rise && bits_seen == lane.width
			|=> !lane.slip;
	endproperty
	a_slip_flag: assert property (p_slip_flag)
		else $error("slip raised on a full word");

endmodule

`default_nettype wire

// File: src/lvds_rx_lane.sv
// Purpose: One differential receive lane with register control.
// Assumes: Bit clock slower than a quarter of clk; pads sampled by clk.
// Notes:   Lane clocks are oversampled, not used as clocks.
`timescale 1ns/1ns
`default_nettype none

module lvds_rx_lane (
	input  wire logic                             clk,
	input  wire logic                             rst_n,
	input  wire logic                             diff_pad_positive,
	input  wire logic                             diff_pad_negative,
	input  wire logic                             serial_bit_clock,
	input  wire logic                             parallel_word_clock,
	input  wire logic [lvds_rx_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [lvds_rx_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                             reg_wr,
	input  wire logic                             reg_rd,
	output var  logic [lvds_rx_pkg::DATA_W-1:0]   reg_rdata,
	output var  logic [lvds_rx_pkg::WORD_W-1:0]   rx_word,
	output var  logic                             rx_word_valid,
	output var  logic                             alternate_bypass_out,
	output var  logic                             alt_to_pll_clkin,
	output var  logic                             alt_to_pll_extfb,
	output var  logic                             odt_enable
);
	import lvds_rx_pkg::*;

	localparam int unsigned PINS = 4;

	logic        deser_en;
	logic [3:0]  width_cfg;
	conn_e       conn;
	logic        odt_cfg;
	logic        slip_sticky;
	logic [15:0] word_count;
	logic [3:0]  pin_raw;
	logic [3:0]  pin_level;
	logic [3:0]  pin_rise;
	logic        pad_bit;
	logic        alt_mode;
	logic        ctrl_wr;
	logic        stat_wr;
	logic [1:0]  conn_code;

	lane_if lane ();

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Three stages; a level is taken only once stages two and three
	// agree, so a single metastable sample never counts as an edge.
	assign pin_raw = {parallel_word_clock, serial_bit_clock,
		diff_pad_negative, diff_pad_positive};

	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : sync_g
			logic s1;
			logic s2;
			logic s3;
			logic level;
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
				end else begin
					s1 <= pin_raw[g];
					s2 <= s1;
					s3 <= s2;
				end
			end
			always_ff @(posedge clk) begin
				if (!rst_n)
					level <= 1'b0;
				else if (s2 == s3)
					level <= s3;
			end
			assign pin_level[g] = level;
			assign pin_rise[g]  = s2 && s3 && !level;
		end
	endgenerate

	// The receiver sees a one while the positive pad is above the
	// negative one; equal levels read as zero.
	assign pad_bit  = pin_level[0] && !pin_level[1];
	assign alt_mode = !deser_en && conn != CONN_NORMAL;

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	assign ctrl_wr   = reg_wr && reg_addr == OFF_CTRL;
	assign stat_wr   = reg_wr && reg_addr == OFF_STATUS;
	assign conn_code = reg_wdata[CTRL_CONN_LSB +: 2];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			deser_en  <= RST_DESER;
			width_cfg <= RST_WIDTH;
			odt_cfg   <= RST_ODT;
		end else if (ctrl_wr) begin
			deser_en  <= reg_wdata[CTRL_DESER_BIT];
			width_cfg <= clamp_width(
				reg_wdata[CTRL_WIDTH_LSB +: 4]);
			odt_cfg   <= reg_wdata[CTRL_ODT_BIT];
		end
	end

	// The unused route code falls back to plain receive.
	always_ff @(posedge clk) begin
		if (!rst_n)
			conn <= CONN_NORMAL;
		else if (ctrl_wr)
			conn <= (conn_code > 2'(CONN_PLL_EXTFB))
				? CONN_NORMAL : conn_e'(conn_code);
	end

	// A slip in the same cycle as its clear stays set.
	always_ff @(posedge clk) begin
		if (!rst_n)
			slip_sticky <= 1'b0;
		else if (lane.slip)
			slip_sticky <= 1'b1;
		else if (stat_wr && reg_wdata[STAT_SLIP_BIT])
			slip_sticky <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			word_count <= 16'h0000;
		else if (lane.word_valid)
			word_count <= 16'(word_count + 16'h0001);
	end

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
			if (reg_rd) begin
				unique case (reg_addr)
					OFF_CTRL: begin
						reg_rdata[CTRL_DESER_BIT]       <= deser_en;
						reg_rdata[CTRL_WIDTH_LSB +: 4]  <= width_cfg;
						reg_rdata[CTRL_CONN_LSB +: 2]   <= conn;
						reg_rdata[CTRL_ODT_BIT]         <= odt_cfg;
					end
					OFF_STATUS: begin
						reg_rdata[STAT_SLIP_BIT] <= slip_sticky;
						reg_rdata[STAT_PAD_BIT]  <= pad_bit;
					end
					OFF_WORD:
						reg_rdata[WORD_W-1:0] <= rx_word;
					OFF_COUNT:
						reg_rdata[15:0] <= word_count;
					default:
						reg_rdata <= '0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Deserializer
	// ----------------------------------------------------------------
	assign lane.enable    = deser_en;
	assign lane.width     = width_cfg;
	assign lane.bit_rise  = pin_rise[2];
	assign lane.bit_value = pad_bit;
	assign lane.word_rise = pin_rise[3];

	lane_shifter u_shifter (
		.clk   (clk),
		.rst_n (rst_n),
		.lane  (lane)
	);

	// ----------------------------------------------------------------
	// Fabric side outputs
	// ----------------------------------------------------------------
	// In bypass the word is refreshed every cycle so the lane behaves
	// as a plain input; an alternate route takes the pad away from it.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_word       <= '0;
			rx_word_valid <= 1'b0;
		end else if (deser_en) begin
			rx_word_valid <= lane.word_valid;
			if (lane.word_valid)
				rx_word <= lane.word;
		end else if (conn == CONN_NORMAL) begin
			rx_word       <= {{(WORD_W-1){1'b0}}, pad_bit};
			rx_word_valid <= 1'b1;
		end else begin
			rx_word       <= '0;
			rx_word_valid <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alternate_bypass_out <= 1'b0;
			alt_to_pll_clkin     <= 1'b0;
			alt_to_pll_extfb     <= 1'b0;
		end else begin
			alternate_bypass_out <= alt_mode && pad_bit;
			alt_to_pll_clkin <= alt_mode
				&& conn == CONN_PLL_CLKIN;
			alt_to_pll_extfb <= alt_mode
				&& conn == CONN_PLL_EXTFB;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			odt_enable <= 1'b0;
		else
			odt_enable <= odt_cfg;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_word_width;
		rx_word_valid && $past(deser_en) |->
			(rx_word & ~width_mask($past(width_cfg))) == '0;
	endproperty
	a_word_width: assert property (p_word_width)
		else $error("word bits above the factor are set");

	property p_bypass;
		!deser_en && conn == CONN_NORMAL ##1 $stable(deser_en)
			&& $stable(conn) |->
			rx_word == {{(WORD_W-1){1'b0}}, $past(pad_bit)}
			&& rx_word_valid;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypass word does not follow the pad");

	property p_alt_gate;
		alternate_bypass_out |-> $past(alt_mode) && $past(pad_bit);
	endproperty
	a_alt_gate: assert property (p_alt_gate)
		else $error("alternate output driven outside bypass");

	property p_route;
		ctrl_wr && !reg_wdata[CTRL_DESER_BIT]
			&& conn_code == 2'(CONN_PLL_CLKIN) |=> ##1
			alt_to_pll_clkin && !alt_to_pll_extfb;
	endproperty
	a_route: assert property (p_route)
		else $error("clock input route not taken");

	property p_odt;
		ctrl_wr |=> ##1 odt_enable == $past(reg_wdata[CTRL_ODT_BIT], 2);
	endproperty
	a_odt: assert property (p_odt)
		else $error("termination does not follow its setting");

	property p_slip_hold;
		lane.slip ##1 !stat_wr |-> slip_sticky [*2];
	endproperty
	a_slip_hold: assert property (p_slip_hold)
		else $error("slip flag lost");

	property p_read_once;
		!reg_rd |=> reg_rdata == '0;
	endproperty
	a_read_once: assert property (p_read_once)
		else $error("read data outside the answer cycle");

	property p_count;
		lane.word_valid |=> word_count == 16'($past(word_count) + 16'h1);
	endproperty
	a_count: assert property (p_count)
		else $error("word counter missed a word");

	property p_alt_follow;
		alt_mode |=> alternate_bypass_out == $past(pad_bit);
	endproperty
	a_alt_follow: assert property (p_alt_follow)
		else $error("alternate output does not follow the pad");

	property p_alt_quiet;
		!alt_mode |=> !alternate_bypass_out && !alt_to_pll_clkin
			&& !alt_to_pll_extfb;
	endproperty
	a_alt_quiet: assert property (p_alt_quiet)
		else $error("alternate path active outside bypass");

	property p_extfb_route;
		alt_mode && conn == CONN_PLL_EXTFB |=> alt_to_pll_extfb
			&& !alt_to_pll_clkin;
	endproperty
	a_extfb_route: assert property (p_extfb_route)
		else $error("feedback route not taken");

	property p_slip_clear;
		stat_wr && reg_wdata[STAT_SLIP_BIT] && !lane.slip |=> !slip_sticky;
	endproperty
	a_slip_clear: assert property (p_slip_clear)
		else $error("slip flag not cleared");

endmodule

`default_nettype wire

// File: verif/serial_tx_model.sv
// Purpose: Board-side differential transmitter that feeds the receive lane.
// Assumes: Runs from the system clock; bit clock stays below clk/4.
// Notes:   Both lane clocks stand still low between frames.
`timescale 1ns/1ns
`default_nettype none

module serial_tx_model (
	input  wire logic clk,
	output var  logic pad_p,
	output var  logic pad_n,
	output var  logic bit_clk,
	output var  logic word_clk
);
	initial begin
		pad_p    = 1'b0;
		pad_n    = 1'b1;
		bit_clk  = 1'b0;
		word_clk = 1'b0;
	end

	task automatic set_level(input logic b);
		@(posedge clk);
		pad_p <= b;
		pad_n <= ~b;
	endtask

	// Sends the low n bits of w, oldest bit first, then one word clock edge.
	task automatic send_word(input logic [7:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			set_level(w[i]);
			repeat (2) @(posedge clk);
			bit_clk <= 1'b1;
			repeat (3) @(posedge clk);
			bit_clk <= 1'b0;
		end
		// The pair no longer carries the last bit once the frame is over.
		set_level(~w[0]);
		@(posedge clk);
		word_clk <= 1'b1;
		repeat (3) @(posedge clk);
		word_clk <= 1'b0;
	endtask
endmodule

`default_nettype wire

// File: verif/lvds_rx_lane_tb_top.sv
// Purpose: Self-checking bench for the differential receive lane.
// Assumes: Register port with read data one cycle after the strobe.
// Notes:   Words are captured from the valid pulse by a monitor process.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
	errors++; $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module lvds_rx_lane_tb_top;
	import lvds_rx_pkg::*;

	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              pad_p;
	logic              pad_n;
	logic              bit_clk;
	logic              word_clk;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic [WORD_W-1:0] rx_word;
	logic              rx_word_valid;
	logic              alt_out;
	logic              to_clkin;
	logic              to_extfb;
	logic              odt_enable;
	logic [WORD_W-1:0] got_word = '0;
	int                got_n = 0;
	int                errors = 0;
	int                check_count = 0;

	always #20 clk = ~clk;

	serial_tx_model tx (.clk(clk), .pad_p(pad_p), .pad_n(pad_n),
		.bit_clk(bit_clk), .word_clk(word_clk));

	lvds_rx_lane uut (.clk(clk), .rst_n(rst_n), .diff_pad_positive(pad_p),
		.diff_pad_negative(pad_n), .serial_bit_clock(bit_clk),
		.parallel_word_clock(word_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rx_word(rx_word),
		.rx_word_valid(rx_word_valid), .alternate_bypass_out(alt_out),
		.alt_to_pll_clkin(to_clkin), .alt_to_pll_extfb(to_extfb),
		.odt_enable(odt_enable));

	always @(posedge clk) begin
		if (rx_word_valid === 1'b1) begin
			got_word <= rx_word;
			got_n    <= got_n + 1;
		end
	end

	function automatic logic [31:0] ctrl(input logic de, input logic [3:0] w,
		input logic [1:0] r, input logic odt);
		return {19'h0, odt, 2'h0, r, w, 3'h0, de};
	endfunction

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#800000;
		errors++;
		conclude();
	end

	initial begin
		logic [31:0] d;
		logic [7:0]  pat;
		int          n0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		reg_read(OFF_CTRL, d);
		`CHECK("ctrl reset", ctrl(1'b1, 4'h8, 2'h0, 1'b0), d)
		#1 `CHECK("odt reset", 1'b0, odt_enable)
		reg_read(4'h2, d);
		`CHECK("unmapped read", 32'h0, d)
		for (int w = 2; w <= 8; w++) begin
			reg_write(OFF_CTRL, ctrl(1'b1, w[3:0], 2'h0, 1'b0));
			tx.send_word(8'h3C, w);
			pat = 8'hB4 + 8'(w * 8'h13);
			// Let the first word land before the count is taken.
			repeat (8) @(posedge clk);
			n0 = got_n;
			tx.send_word(pat, w);
			repeat (8) @(posedge clk);
			`CHECK("word count", n0 + 1, got_n)
			`CHECK("rx word", pat & width_mask(w[3:0]), got_word)
			reg_read(OFF_WORD, d);
			`CHECK("word reg", {24'h0, pat & width_mask(w[3:0])}, d)
		end
		reg_read(OFF_COUNT, d);
		`CHECK("count reg", 32'h0000_000E, d)
		reg_read(OFF_STATUS, d);
		`CHECK("no slip yet", 1'b0, d[STAT_SLIP_BIT])
		// A three-bit frame at factor eight must be flagged.
		tx.send_word(8'h5A, 3);
		repeat (8) @(posedge clk);
		reg_read(OFF_STATUS, d);
		`CHECK("slip set", 1'b1, d[STAT_SLIP_BIT])
		reg_write(OFF_STATUS, 32'h0000_0001);
		reg_read(OFF_STATUS, d);
		`CHECK("slip cleared", 1'b0, d[STAT_SLIP_BIT])
		for (int r = 0; r < 3; r++) begin
			reg_write(OFF_CTRL, ctrl(1'b0, 4'h8, r[1:0], 1'b0));
			for (int b = 1; b >= 0; b--) begin
				tx.set_level(b[0]);
				repeat (8) @(posedge clk);
				#1 `CHECK("bypass word", (r == 0) ? 8'(b) : 8'h00, rx_word)
				`CHECK("bypass valid", r == 0, rx_word_valid)
				`CHECK("alt out", (r != 0) ? b[0] : 1'b0, alt_out)
				`CHECK("to clkin", r == 1, to_clkin)
				`CHECK("to extfb", r == 2, to_extfb)
				reg_read(OFF_STATUS, d);
				`CHECK("pad level", b[0], d[STAT_PAD_BIT])
			end
		end
		tx.set_level(1'b1);
		reg_write(OFF_CTRL, ctrl(1'b1, 4'h8, 2'h1, 1'b1));
		repeat (8) @(posedge clk);
		#1 `CHECK("alt when deser", 1'b0, alt_out)
		`CHECK("clkin when deser", 1'b0, to_clkin)
		`CHECK("odt on", 1'b1, odt_enable)
		reg_read(OFF_CTRL, d);
		`CHECK("ctrl odt", ctrl(1'b1, 4'h8, 2'h1, 1'b1), d)
		reg_write(OFF_CTRL, ctrl(1'b1, 4'hF, 2'h3, 1'b0));
		reg_read(OFF_CTRL, d);
		`CHECK("ctrl clamp high", ctrl(1'b1, 4'h8, 2'h0, 1'b0), d)
		reg_write(OFF_CTRL, ctrl(1'b1, 4'h1, 2'h0, 1'b0));
		reg_read(OFF_CTRL, d);
		`CHECK("ctrl clamp low", ctrl(1'b1, 4'h2, 2'h0, 1'b0), d)
		conclude();
	end
endmodule

`default_nettype wire
